// ---- verilog/ftsp_device.sv ----
`timescale 1ns/100ps
// Flow-through burst memory, device end
module ftsp_device #(
    parameter int DEPTH = ftsp_pkg::DEPTH
) (
    input wire logic core_clk_in, // 10 MHz clock
    input wire logic rst_n_in, // Synchronous reset, active low
    ftsp_if.device bus, // Pins to the master
    output logic selected_out, // Device holds an active access
    output logic burst_order_out // Burst order in use, high interleaved
);

    typedef enum logic [1:0] {FTSP_IDLE, FTSP_READ, FTSP_WRITE} ftsp_op_t;

    ftsp_op_t op_q;
    logic [16:0] base_q;
    logic [1:0] cnt_q;
    logic first_q;
    logic [3:0][7:0] rd_byte;
    logic [3:0] rd_par;
    logic [16:0] cur_addr;
    logic [1:0] low_bits;
    logic sel;
    logic go;
    logic strap_q;

    // ----------------------------------------------------------------
    // Decode
    // ----------------------------------------------------------------
    // All three selects must be active together
    assign sel = !bus.chip_select_low_a_n && bus.chip_select_high && !bus.chip_select_low_b_n;
    assign go = !bus.clock_qualifier_n;

    // Burst address: interleaved xors, linear adds
    assign low_bits = strap_q ? (base_q[1:0] ^ cnt_q) : 2'(base_q[1:0] + cnt_q);
    assign cur_addr = {base_q[16:2], low_bits};

    // Static strap, sampled on every edge so a masked clock cannot hide it;
    // an unknown or floating level reads as high
    always_ff @(posedge core_clk_in) begin
        if (!rst_n_in) begin
            strap_q <= 1'b1;
        end else begin
            strap_q <= bus.burst_order !== 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // Access sequencing
    // ----------------------------------------------------------------
    // Load new access or advance burst; qualifier high holds all
    always_ff @(posedge core_clk_in) begin
        if (!rst_n_in) begin
            op_q <= FTSP_IDLE;
            base_q <= '0;
            cnt_q <= ftsp_pkg::BURST_RST;
        end else if (go) begin
            if (bus.advance_or_load) begin
                cnt_q <= cnt_q + 2'h1;
            end else if (sel) begin
                op_q <= bus.write_n ? FTSP_READ : FTSP_WRITE;
                base_q <= bus.addr;
                cnt_q <= ftsp_pkg::BURST_RST;
            end else begin
                op_q <= FTSP_IDLE;
            end
        end
    end

    // Marks the first recognized cycle after an access ends in a deselect;
    // a read loaded at the next edge must still flow out in its data cycle
    always_ff @(posedge core_clk_in) begin
        if (!rst_n_in) begin
            first_q <= 1'b0;
        end else if (go) begin
            first_q <= (op_q != FTSP_IDLE) && !bus.advance_or_load && !sel;
        end
    end

    // ----------------------------------------------------------------
    // Write path
    // ----------------------------------------------------------------
    // Data is taken at the edge after the address edge; each lane keeps its
    // own byte and parity bit so that one process owns each array
    for (genvar l = 0; l < ftsp_pkg::LANES; l++) begin : g_lane
        logic [8:0] lane_mem [DEPTH];
        always_ff @(posedge core_clk_in) begin
            if (go && op_q == FTSP_WRITE && !bus.byte_lane_write_select_n[l]) begin
                lane_mem[cur_addr] <= {bus.parity_lines[l], bus.dq[l*8 +: 8]};
            end
        end
        // Flows straight from the core, no output register
        assign rd_byte[l] = lane_mem[cur_addr][7:0];
        assign rd_par[l] = lane_mem[cur_addr][8];
    end

    // ----------------------------------------------------------------
    // Read path and drivers
    // ----------------------------------------------------------------
    // Lanes joined back into the shared word
    assign bus.dq_d_out = rd_byte;
    assign bus.par_d_out = rd_par;
    // Drive only for a read, not on first cycle, with enable low
    assign bus.dq_d_oe = (op_q == FTSP_READ) && !first_q && !bus.output_enable_n;

    // Status outputs
    always_ff @(posedge core_clk_in) begin
        if (!rst_n_in) begin
            selected_out <= 1'b0;
            burst_order_out <= 1'b1;
        end else begin
            selected_out <= op_q != FTSP_IDLE;
            burst_order_out <= strap_q;
        end
    end

endmodule : ftsp_device

// ---- verilog/ftsp_pkg.sv ----
package ftsp_pkg;

    // ----------------------------------------------------------------
    // Geometry
    // ----------------------------------------------------------------
    localparam int ADDR_W = 17;
    localparam int DATA_W = 32;
    localparam int LANES = 4;
    localparam int LANE_W = 8;
    localparam int DEPTH = 131072;

    // ----------------------------------------------------------------
    // Values after reset
    // ----------------------------------------------------------------
    localparam logic [1:0] BURST_RST = 2'h0;
    localparam logic [31:0] DATA_RST = 32'h0;

endpackage : ftsp_pkg

// ---- verilog/ftsp_if.sv ----
`timescale 1ns/100ps
// Shared pins between the memory device and its bus master
interface ftsp_if;
    logic chip_select_low_a_n; // Select A, active low
    logic chip_select_high; // Select, active high
    logic chip_select_low_b_n; // Select B, active low
    logic clock_qualifier_n; // Clock edge qualifier, active low
    logic advance_or_load; // High advances burst, low loads
    logic write_n; // Write request, active low
    logic [3:0] byte_lane_write_select_n; // Byte lane write selects
    logic [16:0] addr; // Address
    logic output_enable_n; // Asynchronous output enable
    logic burst_order; // Strap: high interleaved
    logic [31:0] dq_m_out; // Master data out
    logic dq_m_oe; // Master drives data
    logic [3:0] par_m_out; // Master parity out
    logic [31:0] dq_d_out; // Device data out
    logic dq_d_oe; // Device drives data
    logic [3:0] par_d_out; // Device parity out
    logic [31:0] dq; // Resolved data wire
    logic [3:0] parity_lines; // Resolved parity wire

    // Wire resolution: whoever enables drives, else pulled high
    assign dq = dq_d_oe ? dq_d_out : (dq_m_oe ? dq_m_out : 32'hffffffff);
    assign parity_lines = dq_d_oe ? par_d_out : (dq_m_oe ? par_m_out : 4'hf);

    modport device (
        input chip_select_low_a_n, chip_select_high, chip_select_low_b_n, clock_qualifier_n,
        input advance_or_load, write_n, byte_lane_write_select_n, addr, output_enable_n, burst_order,
        input dq, parity_lines,
        output dq_d_out, dq_d_oe, par_d_out
    );
    modport master (
        output chip_select_low_a_n, chip_select_high, chip_select_low_b_n, clock_qualifier_n,
        output advance_or_load, write_n, byte_lane_write_select_n, addr, output_enable_n, burst_order,
        output dq_m_out, dq_m_oe, par_m_out,
        input dq, parity_lines
    );
endinterface : ftsp_if

// ---- verilog/ftsp_master.sv ----
`timescale 1ns/100ps
// Bus master end: runs single reads and writes
module ftsp_master (
    input wire logic core_clk_in, // 10 MHz clock
    input wire logic rst_n_in, // Synchronous reset, active low
    ftsp_if.master bus, // Pins to the device
    input wire logic req_in, // Start an access, pulse
    input wire logic req_write_in, // High for write
    input wire logic [16:0] req_addr_in, // Access address
    input wire logic [35:0] req_wdata_in, // Write data with parity
    input wire logic [3:0] req_be_n_in, // Byte selects, active low
    input wire logic burst_order_in, // Strap level to drive
    output logic busy_out, // Access in progress
    output logic done_out, // Access complete, pulse
    output logic [35:0] rdata_out // Read data with parity
);

    typedef enum logic [1:0] {FTM_IDLE, FTM_ADDR, FTM_DATA} ftm_state_t;
    ftm_state_t st_q;
    logic wr_q;
    logic [35:0] wd_q;
    logic [3:0] be_q;
    logic [16:0] addr_q;

    // Pins driven from registers, except advance_or_load tied low and burst_order from burst_order_in
    assign bus.chip_select_low_a_n = st_q != FTM_ADDR;
    assign bus.chip_select_high = st_q == FTM_ADDR;
    assign bus.chip_select_low_b_n = st_q != FTM_ADDR;
    assign bus.clock_qualifier_n = st_q == FTM_IDLE;
    assign bus.advance_or_load = 1'b0;
    assign bus.write_n = !(st_q == FTM_ADDR && wr_q);
    assign bus.byte_lane_write_select_n = be_q;
    assign bus.addr = addr_q;
    assign bus.output_enable_n = wr_q;
    assign bus.burst_order = burst_order_in;
    assign bus.dq_m_out = wd_q[31:0];
    assign bus.par_m_out = wd_q[35:32];
    assign bus.dq_m_oe = st_q == FTM_DATA && wr_q;

    // Sequence: address cycle then data cycle
    always_ff @(posedge core_clk_in) begin
        if (!rst_n_in) begin
            st_q <= FTM_IDLE;
            wr_q <= 1'b0;
            wd_q <= '0;
            be_q <= 4'hf;
            addr_q <= '0;
            busy_out <= 1'b0;
            done_out <= 1'b0;
            rdata_out <= '0;
        end else begin
            done_out <= 1'b0;
            unique case (st_q)
                FTM_IDLE: begin
                    if (req_in) begin
                        st_q <= FTM_ADDR;
                        wr_q <= req_write_in;
                        wd_q <= req_wdata_in;
                        be_q <= req_be_n_in;
                        addr_q <= req_addr_in;
                        busy_out <= 1'b1;
                    end
                end
                FTM_ADDR: st_q <= FTM_DATA;
                FTM_DATA: begin
                    st_q <= FTM_IDLE;
                    rdata_out <= {bus.parity_lines, bus.dq};
                    busy_out <= 1'b0;
                    done_out <= 1'b1;
                    be_q <= 4'hf;
                    wr_q <= 1'b0;
                end
            endcase
        end
    end

endmodule : ftsp_master

// ---- dv/ftsp_properties.sv ----
`timescale 1ns/100ps
// Pin-level checks on the link between master and device
module ftsp_properties (
    input wire logic core_clk_in, // Clock
    input wire logic rst_n_in, // Reset, active low
    input wire logic chip_select_low_a_n, // Select A
    input wire logic chip_select_high, // Select, active high
    input wire logic chip_select_low_b_n, // Select B
    input wire logic clock_qualifier_n, // Edge qualifier
    input wire logic advance_or_load, // Advance or load
    input wire logic write_n, // Write request
    input wire logic output_enable_n, // Output enable
    input wire logic [31:0] dq_d_out, // Device data
    input wire logic dq_d_oe, // Device drives
    input wire logic dq_m_oe // Master drives
);
    logic sel;
    logic load;

    // Decode of a selected, recognized load edge
    assign sel = !chip_select_low_a_n && chip_select_high && !chip_select_low_b_n;
    assign load = !clock_qualifier_n && !advance_or_load;

    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (!rst_n_in);

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    a_oe_high_floats: assert property (output_enable_n |-> !dq_d_oe)
        else $error("device drives with output enable high");
    a_write_floats: assert property ((load && sel && !write_n) |=> !dq_d_oe)
        else $error("device drives in write data cycle");
    a_deselect_floats: assert property ((load && !sel) |=> !dq_d_oe)
        else $error("device drives after deselect");
    a_stall_holds: assert property (clock_qualifier_n |=> $stable(dq_d_out))
        else $error("device data moved on a masked edge");
    a_write_data_cycle: assert property ((load && sel && !write_n) |=> (dq_m_oe && output_enable_n))
        else $error("master data missing after write address");
    a_no_contention: assert property (!(dq_m_oe && dq_d_oe))
        else $error("both ends drive the data lines");
    a_read_enables: assert property ((load && sel && write_n) |=> !output_enable_n)
        else $error("output enable high in read data cycle");
    a_read_master_float: assert property ((load && sel && write_n) |=> !dq_m_oe)
        else $error("master drives in read data cycle");
    a_read_drives: assert property ((load && sel && write_n) |=> dq_d_oe)
        else $error("device silent in read data cycle");

    // Main scenarios seen
    c_write: cover property (load && sel && !write_n);
    c_read: cover property (load && sel && write_n);
    c_drive: cover property (dq_d_oe);
    c_stall: cover property (clock_qualifier_n);
endmodule : ftsp_properties

// ---- dv/tb_top.sv ----
`timescale 1ns/100ps
`define CHK(nm, exp, got) begin check_count++; if ((got) !== (exp)) begin error_cnt++; \
    $display("mismatch %s expected %h seen %h", nm, exp, got); end end
// Bench: master and device face each other, user side driven here
module tb_top;
    logic core_clk_in = 1'b0;
    logic rst_n_in = 1'b0;
    logic req_in = 1'b0;
    logic req_write_in = 1'b0;
    logic [16:0] req_addr_in = 17'h0;
    logic [35:0] req_wdata_in = 36'h0;
    logic [3:0] req_be_n_in = 4'hf;
    logic burst_order_in = 1'b1;
    logic busy_out, done_out, selected_out, burst_order_out;
    logic [35:0] rdata_out, rd, exp;
    int error_cnt = 0;
    int check_count = 0;

    ftsp_if bus_if ();
    ftsp_device u_ftsp_device (.core_clk_in(core_clk_in), .rst_n_in(rst_n_in), .bus(bus_if),
        .selected_out(selected_out), .burst_order_out(burst_order_out));
    ftsp_master u_ftsp_master (.core_clk_in(core_clk_in), .rst_n_in(rst_n_in), .bus(bus_if), .req_in(req_in),
        .req_write_in(req_write_in), .req_addr_in(req_addr_in), .req_wdata_in(req_wdata_in),
        .req_be_n_in(req_be_n_in), .burst_order_in(burst_order_in), .busy_out(busy_out),
        .done_out(done_out), .rdata_out(rdata_out));
    ftsp_properties u_ftsp_properties (.core_clk_in(core_clk_in), .rst_n_in(rst_n_in),
        .chip_select_low_a_n(bus_if.chip_select_low_a_n), .chip_select_high(bus_if.chip_select_high),
        .chip_select_low_b_n(bus_if.chip_select_low_b_n), .clock_qualifier_n(bus_if.clock_qualifier_n),
        .advance_or_load(bus_if.advance_or_load), .write_n(bus_if.write_n),
        .output_enable_n(bus_if.output_enable_n), .dq_d_out(bus_if.dq_d_out), .dq_d_oe(bus_if.dq_d_oe),
        .dq_m_oe(bus_if.dq_m_oe));

    // Clock, 100 ns period
    initial begin
        forever #50 core_clk_in = ~core_clk_in;
    end

    // ----------------------------------------------------------------
    // Tasks
    // ----------------------------------------------------------------
    task automatic end_sim;
        $display("checks %0d mismatches %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : end_sim

    // One access: request pulse, then wait for done under a bound
    task automatic access(input logic wr, input logic [16:0] a, input logic [35:0] wd, input logic [3:0] be);
        int n;
        n = 0;
        @(posedge core_clk_in);
        req_in <= 1'b1;
        req_write_in <= wr;
        req_addr_in <= a;
        req_wdata_in <= wd;
        req_be_n_in <= be;
        @(posedge core_clk_in);
        req_in <= 1'b0;
        @(negedge core_clk_in);
        `CHK("busy", 1'b1, busy_out)
        `CHK("idle select", 1'b0, selected_out)
        while (done_out !== 1'b1 && n < 20) begin
            @(negedge core_clk_in);
            n++;
        end
        if (n >= 20) begin
            error_cnt++;
            end_sim();
        end
        `CHK("selected", 1'b1, selected_out)
        rd = rdata_out;
    endtask : access

    // Reset for 6 cycles with the given strap level
    task automatic do_reset(input logic strap);
        @(posedge core_clk_in);
        rst_n_in <= 1'b0;
        burst_order_in <= strap;
        repeat (6) @(posedge core_clk_in);
        rst_n_in <= 1'b1;
        repeat (3) @(negedge core_clk_in);
        `CHK("strap", strap, burst_order_out)
    endtask : do_reset

    // Watchdog against a hang
    initial begin
        repeat (3000) @(posedge core_clk_in);
        error_cnt++;
        end_sim();
    end

    // ----------------------------------------------------------------
    // Test sequence
    // ----------------------------------------------------------------
    initial begin
        do_reset(1'b1);
        access(1'b1, 17'h00a5c, 36'h5a1b2c3d4, 4'h0);
        access(1'b0, 17'h00a5c, 36'h0, 4'hf);
        `CHK("full word", 36'h5a1b2c3d4, rd)
        access(1'b1, 17'h00011, 36'h911223344, 4'h0);
        access(1'b1, 17'h00011, 36'h6aabbccdd, 4'hd);
        access(1'b0, 17'h00011, 36'h0, 4'hf);
        `CHK("lane one", 36'hb1122cc44, rd)
        // Lanes one at a time at the top address
        access(1'b1, 17'h1ffff, 36'h0, 4'h0);
        exp = 36'h0;
        for (int l = 0; l < 4; l++) begin
            access(1'b1, 17'h1ffff, 36'hfffffffff, ~(4'h1 << l));
            exp[8*l +: 8] = 8'hff;
            exp[32 + l] = 1'b1;
            access(1'b0, 17'h1ffff, 36'h0, 4'hf);
            `CHK("lane walk", exp, rd)
        end
        do_reset(1'b0);
        access(1'b0, 17'h1ffff, 36'h0, 4'hf);
        `CHK("after reset", 36'hfffffffff, rd)
        end_sim();
    end
endmodule : tb_top
